// >>> logic/sbs_cycle_map.svh
`ifndef SBS_CYCLE_MAP_SVH
`define SBS_CYCLE_MAP_SVH

// Default address width: 2M words
`define SBS_ADDR_W 21
// Least address width accepted: the two burst bits and one bit above them
`define SBS_ADDR_W_MIN 3
// Clock cycles to enter or to leave sleep
`define SBS_SLEEP_CYC 2'h2
`define SBS_SLEEP_ZERO 2'h0
`define SBS_CNT_ONE 2'h1
`define SBS_CNT_RESET 2'h0
// Burst bits within the address
`define SBS_BURST_LSB 0
`define SBS_BURST_MSB 1
`define SBS_LANES_NONE 2'h3
`define SBS_WORD_RESET 18'h00000

`endif

// >>> logic/sbs_pkg.sv
package sbs_pkg;

  typedef enum logic [5:0] {
    SBS_DESEL  = 6'h01,
    SBS_READ   = 6'h02,
    SBS_DREAD  = 6'h04,
    SBS_WRITE  = 6'h08,
    SBS_WABORT = 6'h10,
    SBS_SLEEP  = 6'h20
  } sbs_op_t;

  typedef struct packed {
    logic par;
    logic [7:0] data;
  } sbs_lane_t;

  typedef sbs_lane_t [1:0] sbs_word_t;

  typedef struct packed {
    logic chipSelectFirstN;
    logic chipSelectSecond;
    logic chipSelectThirdN;
    logic advanceOrLoad;
    logic writeStrobeN;
    logic [1:0] laneWriteSelN;
    logic clockQualifierN;
    logic sleepRequest;
  } sbs_ctrl_t;

endpackage

// >>> logic/sbs_cycle_decode.sv
`timescale 1ns/100ps
`include "sbs_cycle_map.svh"

module sbs_cycle_decode #(
  parameter int ADDR_W = `SBS_ADDR_W
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire sbs_pkg::sbs_ctrl_t ctrl,
  input wire logic [ADDR_W-1:0] extAddr,
  input wire logic burstOrder,
  input wire logic outGateN,
  input wire sbs_pkg::sbs_word_t dqIn,
  output sbs_pkg::sbs_word_t dqOut,
  output logic dqOe,
  output sbs_pkg::sbs_op_t opState,
  output logic asleep
);

  generate
    if (ADDR_W < `SBS_ADDR_W_MIN) begin : g_bad_width
      $error("sbs_cycle_decode: ADDR_W too small");
    end
  endgenerate

  function automatic logic [1:0] burstLow(input logic [1:0] start,
                                          input logic [1:0] step,
                                          input logic order);
    burstLow = order ? (start ^ step) : 2'(start + step);
  endfunction

  function automatic logic anyLane(input logic [1:0] selN);
    anyLane = (selN != `SBS_LANES_NONE);
  endfunction

  sbs_pkg::sbs_word_t mem [2**ADDR_W];

  sbs_pkg::sbs_op_t op_r, op_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [1:0] startLow_r, startLow_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic order_r, order_nxt;
  logic burstWr_r, burstWr_nxt;
  logic [1:0] wrSel_r, wrSel_nxt;
  logic [1:0] slp_r, slp_nxt;
  logic asleep_r, asleep_nxt;
  sbs_pkg::sbs_word_t dqOut_r, dqOut_nxt;
  logic qual;
  logic sel;
  logic isRead;
  logic doWrite;
  sbs_pkg::sbs_op_t rdOp;
  sbs_pkg::sbs_op_t wrOp;

  assign qual = !ctrl.clockQualifierN;
  assign sel = !ctrl.chipSelectFirstN && ctrl.chipSelectSecond &&
               !ctrl.chipSelectThirdN;
  assign rdOp = outGateN ? sbs_pkg::SBS_DREAD : sbs_pkg::SBS_READ;
  assign wrOp = anyLane(ctrl.laneWriteSelN) ?
                sbs_pkg::SBS_WRITE : sbs_pkg::SBS_WABORT;
  // Pending write completes on the next qualified edge; a sleep request before or on that edge drops it
  assign doWrite = qual && !ctrl.sleepRequest &&
                   (op_r == sbs_pkg::SBS_WRITE);
  assign isRead = (op_r == sbs_pkg::SBS_READ) ||
                  (op_r == sbs_pkg::SBS_DREAD);

  always_comb begin
    op_nxt = op_r;
    addr_nxt = addr_r;
    startLow_nxt = startLow_r;
    cnt_nxt = cnt_r;
    order_nxt = order_r;
    burstWr_nxt = burstWr_r;
    wrSel_nxt = wrSel_r;
    slp_nxt = slp_r;
    asleep_nxt = asleep_r;
    if (ctrl.sleepRequest) begin
      op_nxt = sbs_pkg::SBS_SLEEP;
      if (slp_r != `SBS_SLEEP_CYC) begin
        slp_nxt = 2'(slp_r + `SBS_CNT_ONE);
      end
      asleep_nxt = (slp_nxt == `SBS_SLEEP_CYC);
    end else if (op_r == sbs_pkg::SBS_SLEEP) begin
      asleep_nxt = 1'b0;
      if (slp_r != `SBS_SLEEP_ZERO) begin
        slp_nxt = 2'(slp_r - `SBS_CNT_ONE);
      end
      if (slp_r <= `SBS_CNT_ONE) begin
        op_nxt = sbs_pkg::SBS_DESEL;
      end
    end else if (qual) begin
      if (!ctrl.advanceOrLoad) begin
        if (!sel) begin
          op_nxt = sbs_pkg::SBS_DESEL;
        end else begin
          addr_nxt = extAddr;
          startLow_nxt = extAddr[`SBS_BURST_MSB:`SBS_BURST_LSB];
          cnt_nxt = `SBS_CNT_RESET;
          order_nxt = burstOrder;
          burstWr_nxt = !ctrl.writeStrobeN;
          wrSel_nxt = ctrl.laneWriteSelN;
          op_nxt = ctrl.writeStrobeN ? rdOp : wrOp;
        end
      end else if (op_r != sbs_pkg::SBS_DESEL) begin
        cnt_nxt = 2'(cnt_r + `SBS_CNT_ONE);
        addr_nxt[`SBS_BURST_MSB:`SBS_BURST_LSB] =
          burstLow(startLow_r, cnt_nxt, order_r);
        wrSel_nxt = ctrl.laneWriteSelN;
        op_nxt = burstWr_r ? wrOp : rdOp;
      end
    end
  end

  always_comb begin
    dqOut_nxt = dqOut_r;
    if ((op_nxt == sbs_pkg::SBS_READ) || (op_nxt == sbs_pkg::SBS_DREAD)) begin
      dqOut_nxt = mem[addr_nxt];
      // Bypass a write finishing on the same edge to the same word
      for (int i = 0; i < 2; i++) begin
        if (doWrite && !wrSel_r[i] && (addr_r == addr_nxt)) begin
          dqOut_nxt[i] = dqIn[i];
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      op_r <= sbs_pkg::SBS_DESEL;
      addr_r <= '0;
      startLow_r <= `SBS_CNT_RESET;
      cnt_r <= `SBS_CNT_RESET;
      order_r <= 1'b0;
      burstWr_r <= 1'b0;
      wrSel_r <= `SBS_LANES_NONE;
      slp_r <= `SBS_SLEEP_ZERO;
      asleep_r <= 1'b0;
      dqOut_r <= `SBS_WORD_RESET;
    end else begin
      op_r <= op_nxt;
      addr_r <= addr_nxt;
      startLow_r <= startLow_nxt;
      cnt_r <= cnt_nxt;
      order_r <= order_nxt;
      burstWr_r <= burstWr_nxt;
      wrSel_r <= wrSel_nxt;
      slp_r <= slp_nxt;
      asleep_r <= asleep_nxt;
      dqOut_r <= dqOut_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    for (int i = 0; i < 2; i++) begin
      if (doWrite && !wrSel_r[i]) begin
        mem[addr_r][i] <= dqIn[i];
      end
    end
  end

  // Gate is live, not sampled; writes and deselect mask it
  assign dqOe = isRead && !outGateN;
  assign dqOut = dqOut_r;
  assign opState = op_r;
  assign asleep = asleep_r;

  property p_read_start;
    @(posedge core_clk) disable iff (rst)
      (qual && !ctrl.sleepRequest && op_r != sbs_pkg::SBS_SLEEP && sel &&
       !ctrl.advanceOrLoad && ctrl.writeStrobeN && !outGateN)
      |=> (op_r == sbs_pkg::SBS_READ) && (dqOe == !outGateN);
  endproperty
  a_read_start: assert property (p_read_start)
    else $error("read start not taken");

  property p_dummy;
    @(posedge core_clk) disable iff (rst)
      (op_r == sbs_pkg::SBS_DREAD && outGateN) |-> !dqOe;
  endproperty
  a_dummy: assert property (p_dummy)
    else $error("dummy read drove lines");

  property p_write_start;
    @(posedge core_clk) disable iff (rst)
      (qual && !ctrl.sleepRequest && op_r != sbs_pkg::SBS_SLEEP && sel &&
       !ctrl.advanceOrLoad && !ctrl.writeStrobeN &&
       anyLane(ctrl.laneWriteSelN))
      |=> (op_r == sbs_pkg::SBS_WRITE) ##1 !dqOe || op_r != sbs_pkg::SBS_WRITE;
  endproperty
  a_write_start: assert property (p_write_start)
    else $error("write start not taken");

  property p_abort;
    @(posedge core_clk) disable iff (rst)
      (qual && !ctrl.sleepRequest && op_r != sbs_pkg::SBS_SLEEP && sel &&
       !ctrl.advanceOrLoad && !ctrl.writeStrobeN &&
       !anyLane(ctrl.laneWriteSelN)) |=> op_r == sbs_pkg::SBS_WABORT && !dqOe;
  endproperty
  a_abort: assert property (p_abort)
    else $error("write abort not taken");

  property p_stall;
    @(posedge core_clk) disable iff (rst)
      (!qual && !ctrl.sleepRequest && op_r != sbs_pkg::SBS_SLEEP)
      |=> $stable(op_r) && $stable(addr_r) && $stable(cnt_r);
  endproperty
  a_stall: assert property (p_stall)
    else $error("stalled edge changed state");

  property p_write_hiz;
    @(posedge core_clk) disable iff (rst)
      (op_r == sbs_pkg::SBS_WRITE || op_r == sbs_pkg::SBS_WABORT) |-> !dqOe;
  endproperty
  a_write_hiz: assert property (p_write_hiz)
    else $error("drivers on in write cycle");

  property p_read_drive;
    @(posedge core_clk) disable iff (rst)
      (op_r == sbs_pkg::SBS_READ && !outGateN) |-> dqOe;
  endproperty
  a_read_drive: assert property (p_read_drive)
    else $error("read not driven");

  property p_powerup;
    @(posedge core_clk)
      rst |=> op_r == sbs_pkg::SBS_DESEL && !dqOe && !asleep;
  endproperty
  a_powerup: assert property (p_powerup)
    else $error("not deselected after reset");

  property p_counter;
    @(posedge core_clk) disable iff (rst)
      (qual && !ctrl.sleepRequest && ctrl.advanceOrLoad &&
       op_r != sbs_pkg::SBS_DESEL && op_r != sbs_pkg::SBS_SLEEP)
      |=> cnt_r == 2'($past(cnt_r) + 2'h1) && $stable(burstWr_r);
  endproperty
  a_counter: assert property (p_counter)
    else $error("burst counter did not step");

  property p_sleep;
    @(posedge core_clk) disable iff (rst)
      ctrl.sleepRequest [*2] |=> op_r == sbs_pkg::SBS_SLEEP && asleep && !dqOe;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep not reached in two cycles");

endmodule

// >>> test/sbs_ctrl_model.sv
`timescale 1ns/100ps
module sbs_ctrl_model (
  input wire logic core_clk,
  output sbs_pkg::sbs_ctrl_t ctrl,
  output logic [20:0] extAddr,
  output logic burstOrder,
  output logic outGateN,
  output sbs_pkg::sbs_word_t dqIn
);
  initial begin
    ctrl = sbs_pkg::sbs_ctrl_t'(9'h15C);
    extAddr = 21'h000000;
    burstOrder = 1'b0;
    outGateN = 1'b0;
    dqIn = 18'h00000;
  end
  // Drive after falling edge, hold through the rising edge
  task automatic cyc(input logic [8:0] c, input logic [20:0] a,
    input logic wd, input logic [17:0] d);
    @(negedge core_clk);
    ctrl = sbs_pkg::sbs_ctrl_t'(c);
    extAddr = a;
    // Released bus toggles so stale data never passes
    dqIn = sbs_pkg::sbs_word_t'(wd ? d : ~dqIn);
    @(posedge core_clk);
    #1;
  endtask
endmodule

// >>> test/sbs_cycle_decode_bench.sv
`timescale 1ns/100ps
module sbs_cycle_decode_bench;
  localparam logic [8:0] RDL = 9'h09C;
  localparam logic [8:0] WRL = 9'h080;
  localparam logic [8:0] WL0 = 9'h088;
  localparam logic [8:0] WL1 = 9'h084;
  localparam logic [8:0] WAB = 9'h08C;
  localparam logic [8:0] AV0 = 9'h170;
  localparam logic [8:0] AV1 = 9'h17C;
  localparam logic [8:0] STL = 9'h15E;
  localparam logic [8:0] IDL = 9'h15C;
  localparam logic [8:0] SLP = 9'h15D;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  sbs_pkg::sbs_ctrl_t ctrl;
  logic [20:0] extAddr;
  logic burstOrder;
  logic outGateN;
  sbs_pkg::sbs_word_t dqIn;
  sbs_pkg::sbs_word_t dqOut;
  logic dqOe;
  logic asleep;
  sbs_pkg::sbs_op_t opState;
  int fail_count = 0;
  int checks = 0;
  logic [8:0] dsl [3] = '{9'h19C, 9'h0DC, 9'h01C};
  always #5 core_clk = ~core_clk;
  sbs_ctrl_model ctl (.core_clk(core_clk), .ctrl(ctrl),
    .extAddr(extAddr), .burstOrder(burstOrder), .outGateN(outGateN),
    .dqIn(dqIn));
  sbs_cycle_decode uut (.core_clk(core_clk), .rst(rst), .ctrl(ctrl),
    .extAddr(extAddr), .burstOrder(burstOrder), .outGateN(outGateN),
    .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe), .opState(opState),
    .asleep(asleep));
  task automatic cw(input logic [17:0] g, input logic [17:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cop(input sbs_pkg::sbs_op_t g, input logic [5:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  function automatic logic [17:0] dv(input int k);
    return 18'(k * 18'h0F0F + 18'h00101);
  endfunction
  task automatic t_wr;
    ctl.cyc(WRL, 21'h000010, 1'b0, 18'h00000);
    cop(opState, 6'h08);
    cw(dqOe, 1'b0);
    // Stalled edge must not take the pending write data
    ctl.cyc(STL, 21'h000000, 1'b0, 18'h00000);
    cop(opState, 6'h08);
    ctl.cyc(IDL, 21'h000000, 1'b1, 18'h2A55A);
    ctl.cyc(RDL, 21'h000010, 1'b0, 18'h00000);
    cop(opState, 6'h02);
    cw(dqOut, 18'h2A55A);
    cw(dqOe, 1'b1);
  endtask
  task automatic t_lanes;
    ctl.cyc(WRL, 21'h000020, 1'b0, 18'h00000);
    ctl.cyc(WL0, 21'h000020, 1'b1, 18'h3FFFF);
    ctl.cyc(WAB, 21'h000020, 1'b1, 18'h00000);
    cop(opState, 6'h10);
    cw(dqOe, 1'b0);
    // Abort data all ones: a stray write shows in lane 0
    ctl.cyc(WL1, 21'h000020, 1'b1, 18'h3FFFF);
    ctl.cyc(RDL, 21'h000020, 1'b1, 18'h2AA55);
    cw(dqOut, 18'h2AA00);
  endtask
  task automatic t_dummy;
    ctl.outGateN = 1'b1;
    ctl.cyc(RDL, 21'h000010, 1'b0, 18'h00000);
    cop(opState, 6'h04);
    cw(dqOe, 1'b0);
    ctl.cyc(AV1, 21'h000000, 1'b0, 18'h00000);
    cop(opState, 6'h04);
    cw(dqOe, 1'b0);
    #2 ctl.outGateN = 1'b0;
    #1 cw(dqOe, 1'b1);
  endtask
  task automatic t_burst(input logic o, input logic [7:0] ix);
    ctl.burstOrder = 1'b0;
    ctl.cyc(WRL, 21'h000041, 1'b0, 18'h00000);
    for (int k = 0; k < 3; k++)
      ctl.cyc(AV0, 21'h000000, 1'b1, dv(k));
    ctl.burstOrder = o;
    ctl.cyc(RDL, 21'h000041, 1'b1, dv(3));
    cw(dqOut, dv(ix[7:6]));
    ctl.cyc(STL, 21'h000000, 1'b0, 18'h00000);
    cop(opState, 6'h02);
    cw(dqOut, dv(ix[7:6]));
    for (int k = 2; k >= 0; k--) begin
      ctl.cyc(AV1, 21'h000000, 1'b0, 18'h00000);
      cw(dqOut, dv(ix[2*k+:2]));
    end
  endtask
  task automatic t_desel;
    foreach (dsl[i]) begin
      ctl.cyc(dsl[i], 21'h000010, 1'b0, 18'h00000);
      cop(opState, 6'h01);
      cw(dqOe, 1'b0);
      ctl.cyc(AV1, 21'h000000, 1'b0, 18'h00000);
      cop(opState, 6'h01);
    end
  endtask
  task automatic t_sleep;
    ctl.cyc(SLP, 21'h000000, 1'b0, 18'h00000);
    cop(opState, 6'h20);
    cw(dqOe, 1'b0);
    ctl.cyc(SLP, 21'h000000, 1'b0, 18'h00000);
    cw(asleep, 1'b1);
    ctl.cyc(IDL, 21'h000000, 1'b0, 18'h00000);
    cop(opState, 6'h20);
    ctl.cyc(IDL, 21'h000000, 1'b0, 18'h00000);
    cop(opState, 6'h01);
  endtask
  initial begin
    #50000;
    fail_count++;
    finish_test();
  end
  initial begin
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    cop(opState, 6'h01);
    cw(dqOe, 1'b0);
    t_wr();
    t_lanes();
    t_dummy();
    t_burst(1'b0, 8'h1B);
    t_burst(1'b1, 8'h39);
    t_desel();
    t_sleep();
    finish_test();
  end
endmodule
